// >>> gpiop_pkg.sv
package gpiop_pkg;
   localparam int NPINS = 8;
   // Interrupt trigger encodings
   typedef enum logic [2:0] {
      GPIOP_TRIG_FALL = 3'h0,
      GPIOP_TRIG_RISE = 3'h1,
      GPIOP_TRIG_BOTH = 3'h2,
      GPIOP_TRIG_LOW = 3'h3,
      GPIOP_TRIG_HIGH = 3'h4
   } gpiop_trig_t;
   // Drive strength encodings
   typedef enum logic [1:0] {
      GPIOP_DRV_2MA = 2'h0,
      GPIOP_DRV_4MA = 2'h1,
      GPIOP_DRV_8MA = 2'h2
   } gpiop_drv_t;
   // Per-pin configuration
   typedef struct packed {
      logic dir_out;
      gpiop_trig_t trig;
      gpiop_drv_t drive;
      logic slew;
      logic pull_up;
      logic pull_down;
      logic open_drain;
      logic periph;
   } gpiop_cfg_t;
   localparam gpiop_cfg_t GPIOP_CFG_RST = '{dir_out: 1'b0,
      trig: GPIOP_TRIG_FALL, drive: GPIOP_DRV_2MA, slew: 1'b0,
      pull_up: 1'b0, pull_down: 1'b0, open_drain: 1'b0, periph: 1'b0};
   // Pad controls presented per pin
   typedef struct packed {
      gpiop_drv_t drive;
      logic slew;
      logic pull_up;
      logic pull_down;
   } gpiop_pad_t;
   localparam gpiop_pad_t GPIOP_PAD_RST = '{drive: GPIOP_DRV_2MA,
      slew: 1'b0, pull_up: 1'b0, pull_down: 1'b0};
   localparam logic [7:0] GPIOP_DATA_RST = 8'h00;
endpackage : gpiop_pkg

// >>> gpiop_port.sv
`timescale 1ns/10ps
//
// Contract
// - Eight pins each set as input or output, all inputs after reset.
// - Inputs raise interrupts on high, low, rising, falling or both edges.
// - Drive is 2, 4 or 8 mA, slew only with 8 mA, 2 mA after reset.
// - Weak pull-up or pull-down per pin, none after reset.
// - Open-drain per pin instead of push-pull, push-pull after reset.
// - Pin owned by GPIO or peripheral, GPIO after reset.
// - Address bits of one data access form a per-pin mask.
// - Mask bit n selects pin n.
// - A masked read returns only the selected pins.
// - A masked write updates all selected pins at once, others unchanged.
module gpiop_port
   import gpiop_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic srst,
   // Configuration write, one pin group per access
   input wire logic cfg_we,
   input wire logic [7:0] cfg_pins,
   input wire gpiop_cfg_t cfg_wdata,
   // Masked data access, pin_select_mask from address bits
   input wire logic data_we,
   input wire logic data_re,
   input wire logic [7:0] pin_select_mask,
   input wire logic [7:0] data_wdata,
   output logic [7:0] data_rdata,
   // Interrupt control
   input wire logic int_en_we,
   input wire logic [7:0] int_en_wdata,
   input wire logic int_clr,
   input wire logic [7:0] int_clr_pins,
   output logic [7:0] int_raw,
   output logic [7:0] int_masked,
   output logic port_irq,
   // Peripheral side
   input wire logic [7:0] periph_out,
   input wire logic [7:0] periph_oe,
   input wire logic [7:0] periph_present,
   output logic [7:0] periph_in,
   // Pads
   input wire logic [7:0] pad_in,
   output logic [7:0] pad_out,
   output logic [7:0] pad_oe,
   output gpiop_pad_t [7:0] pad_ctl
);
   //--------------------------------------------------
   // Input synchroniser
   //--------------------------------------------------
   logic [7:0] sync1_r, sync2_r, prev_r;
   logic [7:0] sync1_nxt, sync2_nxt, prev_nxt;
   always_comb begin
      sync1_nxt = pad_in;
      sync2_nxt = sync1_r;
      prev_nxt = sync2_r;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         sync1_r <= 8'h00;
         sync2_r <= 8'h00;
         prev_r <= 8'h00;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r <= prev_nxt;
      end
   end
   //--------------------------------------------------
   // Configuration and data registers
   //--------------------------------------------------
   gpiop_cfg_t [7:0] cfg_r, cfg_nxt;
   logic [7:0] dout_r, dout_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   always_comb begin
      cfg_nxt = cfg_r;
      dout_nxt = dout_r;
      rdata_nxt = rdata_r;
      for (int i = 0; i < NPINS; i++) begin
         if (cfg_we && cfg_pins[i]) begin
            cfg_nxt[i] = cfg_wdata;
            // Slew control only meaningful with 8 mA
            if (cfg_wdata.drive != GPIOP_DRV_8MA)
               cfg_nxt[i].slew = 1'b0;
         end
      end
      if (data_we)
         dout_nxt = (dout_r & ~pin_select_mask)
                  | (data_wdata & pin_select_mask);
      if (data_re)
         rdata_nxt = sync2_r & pin_select_mask;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cfg_r <= {NPINS{GPIOP_CFG_RST}};
         dout_r <= GPIOP_DATA_RST;
         rdata_r <= 8'h00;
      end else begin
         cfg_r <= cfg_nxt;
         dout_r <= dout_nxt;
         rdata_r <= rdata_nxt;
      end
   end
   //--------------------------------------------------
   // Interrupt detection
   //--------------------------------------------------
   logic [7:0] hit, raw_r, raw_nxt, en_r, en_nxt;
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         case (cfg_r[i].trig)
            GPIOP_TRIG_FALL: hit[i] = prev_r[i] & ~sync2_r[i];
            GPIOP_TRIG_RISE: hit[i] = ~prev_r[i] & sync2_r[i];
            GPIOP_TRIG_BOTH: hit[i] = prev_r[i] ^ sync2_r[i];
            GPIOP_TRIG_LOW: hit[i] = ~sync2_r[i];
            GPIOP_TRIG_HIGH: hit[i] = sync2_r[i];
            default: hit[i] = 1'b0;
         endcase
         // Only input-mode GPIO pins trigger
         if (cfg_r[i].dir_out || cfg_r[i].periph)
            hit[i] = 1'b0;
      end
      en_nxt = int_en_we ? int_en_wdata : en_r;
      raw_nxt = raw_r;
      if (int_clr)
         raw_nxt = raw_r & ~int_clr_pins;
      raw_nxt = raw_nxt | hit;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         raw_r <= 8'h00;
         en_r <= 8'h00;
      end else begin
         raw_r <= raw_nxt;
         en_r <= en_nxt;
      end
   end
   //--------------------------------------------------
   // Pad and output registers
   //--------------------------------------------------
   logic [7:0] pout_nxt, poe_nxt, pin_nxt, masked_nxt;
   gpiop_pad_t [7:0] pctl_nxt;
   logic irq_nxt;
   always_comb begin
      for (int i = 0; i < NPINS; i++) begin
         logic own_p, drv, dval;
         own_p = cfg_r[i].periph & periph_present[i];
         drv = own_p ? periph_oe[i] : cfg_r[i].dir_out;
         dval = own_p ? periph_out[i] : dout_r[i];
         pout_nxt[i] = cfg_r[i].open_drain ? 1'b0 : dval;
         poe_nxt[i] = cfg_r[i].open_drain ? (drv & ~dval) : drv;
         pin_nxt[i] = own_p & sync2_r[i];
         pctl_nxt[i].drive = cfg_r[i].drive;
         pctl_nxt[i].slew = cfg_r[i].slew;
         pctl_nxt[i].pull_up = cfg_r[i].pull_up;
         pctl_nxt[i].pull_down = cfg_r[i].pull_down;
      end
      masked_nxt = raw_nxt & en_nxt;
      irq_nxt = |masked_nxt;
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         pad_out <= 8'h00;
         pad_oe <= 8'h00;
         periph_in <= 8'h00;
         pad_ctl <= {NPINS{GPIOP_PAD_RST}};
         int_masked <= 8'h00;
         port_irq <= 1'b0;
      end else begin
         pad_out <= pout_nxt;
         pad_oe <= poe_nxt;
         periph_in <= pin_nxt;
         pad_ctl <= pctl_nxt;
         int_masked <= masked_nxt;
         port_irq <= irq_nxt;
      end
   end
   assign data_rdata = rdata_r;
   assign int_raw = raw_r;
   //--------------------------------------------------
   // Checks
   //--------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   sequence s_rise(i); !prev_r[i] && sync2_r[i]; endsequence
   sequence s_rise_armed(i);
      s_rise(i) ##0 (cfg_r[i].trig == GPIOP_TRIG_RISE
      && !cfg_r[i].dir_out && !cfg_r[i].periph);
   endsequence
   a_reset_input: assert property ($past(srst) |-> pad_oe == 8'h00)
      else $error("pads driven after reset");
   a_rise_latch: assert property (s_rise_armed(1) |=> raw_r[1])
      else $error("rising edge not latched");
   a_out_no_trig: assert property (
      cfg_r[1].dir_out && !raw_r[1] |=> !raw_r[1])
      else $error("output pin raised status");
   a_slew_only8: assert property (
      cfg_r[1].slew |-> cfg_r[1].drive == GPIOP_DRV_8MA)
      else $error("slew without 8 mA");
   a_pull_follow: assert property (
      ##1 pad_ctl[1].pull_up == $past(cfg_r[1].pull_up))
      else $error("pull not presented");
   a_od_nohigh: assert property (cfg_r[0].open_drain |=> !pad_out[0])
      else $error("open drain drove high");
   a_gpio_own: assert property (
      !cfg_r[3].periph && !cfg_r[3].dir_out |=> !pad_oe[3])
      else $error("input pin driven");
   a_absent_periph: assert property (
      cfg_r[6].periph && !periph_present[6] && !cfg_r[6].open_drain
      |=> !periph_in[6] && pad_oe[6] == $past(cfg_r[6].dir_out))
      else $error("absent peripheral took pin");
   a_read_mask: assert property (
      data_re |=> (data_rdata & ~$past(pin_select_mask)) == 8'h00)
      else $error("unselected read bit set");
   a_write_mask: assert property (
      data_we |=> dout_r == (($past(dout_r) & ~$past(pin_select_mask))
      | ($past(data_wdata) & $past(pin_select_mask))))
      else $error("masked write wrong");
   a_int_clear: assert property (
      int_clr && int_clr_pins[0] && !hit[0] |=> !raw_r[0])
      else $error("status not cleared");
   a_irq_masked: assert property (
      int_masked == (raw_r & en_r) && port_irq == |int_masked)
      else $error("irq not from masked status");
endmodule : gpiop_port

// >>> gpiop_pins_model.sv
`timescale 1ns/10ps
// ---------------------------------------------
// Pins: port drive wins, else external driver
// ---------------------------------------------
module gpiop_pins_model
   import gpiop_pkg::*;
(
   // Port side
   input wire logic [7:0] pad_out,
   input wire logic [7:0] pad_oe,
   // External side
   input wire logic [7:0] ext_val,
   output logic [7:0] pad_in
);
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule : gpiop_pins_model

// >>> tb_general_purpose_io_port.sv
`timescale 1ns/10ps
module tb_general_purpose_io_port;
   import gpiop_pkg::*;
   logic sys_clk = 1'b0, srst = 1'b1, cfg_we = 1'b0, data_we = 1'b0;
   logic data_re = 1'b0, int_en_we = 1'b0, int_clr = 1'b0, port_irq;
   logic [7:0] cfg_pins = 8'h00, pin_select_mask = 8'h00;
   logic [7:0] data_wdata = 8'h00, int_en_wdata = 8'h00;
   logic [7:0] int_clr_pins = 8'h00, ext_val = 8'h00;
   logic [7:0] periph_out = 8'hff, periph_oe = 8'hff;
   logic [7:0] periph_present = 8'h20;
   logic [7:0] data_rdata, int_raw, int_masked, periph_in;
   logic [7:0] pad_in, pad_out, pad_oe;
   gpiop_cfg_t cfg_wdata = GPIOP_CFG_RST;
   gpiop_cfg_t c;
   gpiop_pad_t [7:0] pad_ctl;
   int bad_count = 0, total_checks = 0, cyc = 0;
   always #5 sys_clk = ~sys_clk;
   gpiop_port u_gpiop_port (.sys_clk, .srst, .cfg_we, .cfg_pins,
      .cfg_wdata, .data_we, .data_re, .pin_select_mask, .data_wdata,
      .data_rdata, .int_en_we, .int_en_wdata, .int_clr, .int_clr_pins,
      .int_raw, .int_masked, .port_irq, .periph_out, .periph_oe,
      .periph_present, .periph_in, .pad_in, .pad_out, .pad_oe, .pad_ctl);
   gpiop_pins_model u_gpiop_pins_model (.pad_out, .pad_oe, .ext_val,
      .pad_in);
   // ---------------------------------------------
   // Access tasks; strobes stay up until idle
   // ---------------------------------------------
   task step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step
   task idle(input int n);
      {cfg_we, data_we, data_re, int_en_we, int_clr} = 5'h00;
      step(n);
   endtask : idle
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task cfg(input logic [7:0] p);
      cfg_pins = p;
      cfg_wdata = c;
      cfg_we = 1'b1;
      step(1);
   endtask : cfg
   task wr(input logic [7:0] m, input logic [7:0] d);
      pin_select_mask = m;
      data_wdata = d;
      data_we = 1'b1;
      step(1);
   endtask : wr
   task rd(input logic [7:0] m, input logic [7:0] exp);
      pin_select_mask = m;
      data_re = 1'b1;
      step(1);
      chk(data_rdata, exp);
   endtask : rd
   task ctl(input logic en, input logic clr, input logic [7:0] v);
      int_en_we = en;
      int_clr = clr;
      int_en_wdata = v;
      int_clr_pins = v;
      step(1);
   endtask : ctl
   task results;
      if (bad_count == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : results
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 1000) begin
         bad_count++;
         results();
      end
   end
   // ---------------------------------------------
   // Tests
   // ---------------------------------------------
   initial begin
      step(4);
      srst = 1'b0;
      step(1);
      chk(pad_oe | pad_out, 8'h00);
      chk(int_raw | 8'(port_irq), 8'h00);
      for (int i = 0; i < 8; i++) chk({3'h0, pad_ctl[i]}, 8'h00);
      c = GPIOP_CFG_RST;
      for (int i = 0; i < 5; i++) begin
         c.trig = gpiop_trig_t'(i);
         cfg(8'h01 << i);
      end
      idle(1);
      ctl(1'b0, 1'b1, 8'hff);
      idle(6);
      chk(int_raw, 8'h08);
      chk(8'(port_irq), 8'h00);
      ctl(1'b1, 1'b0, 8'hff);
      idle(2);
      chk({int_masked[6:0], port_irq}, 8'h11);
      ext_val = 8'hff;
      step(6);
      chk(int_raw, 8'h1e);
      ctl(1'b0, 1'b1, 8'hff);
      idle(3);
      chk(int_raw, 8'h10);
      ext_val = 8'h00;
      step(6);
      chk(int_raw, 8'hfd);
      ctl(1'b1, 1'b0, 8'h00);
      idle(2);
      chk(int_masked | 8'(port_irq), 8'h00);
      c = GPIOP_CFG_RST;
      c.dir_out = 1'b1;
      cfg(8'hff);
      idle(1);
      wr(8'h09, 8'hff);
      wr(8'hf0, 8'ha5);
      idle(2);
      chk(pad_out, 8'ha9);
      chk(pad_oe, 8'hff);
      c.dir_out = 1'b0;
      cfg(8'hf0);
      ext_val = 8'h5a;
      idle(5);
      rd(8'h3c, 8'h18);
      idle(1);
      c.drive = GPIOP_DRV_8MA;
      c.slew = 1'b1;
      c.pull_up = 1'b1;
      cfg(8'h02);
      c.drive = GPIOP_DRV_4MA;
      c.pull_up = 1'b0;
      c.pull_down = 1'b1;
      cfg(8'h04);
      idle(2);
      chk({3'h0, pad_ctl[1]}, 8'h16);
      chk({3'h0, pad_ctl[2]}, 8'h09);
      c = GPIOP_CFG_RST;
      c.dir_out = 1'b1;
      c.open_drain = 1'b1;
      cfg(8'h01);
      idle(1);
      wr(8'h01, 8'h00);
      idle(2);
      chk({6'h0, pad_oe[0], pad_out[0]}, 8'h02);
      wr(8'h01, 8'hff);
      idle(2);
      chk({6'h0, pad_oe[0], pad_out[0]}, 8'h00);
      c = GPIOP_CFG_RST;
      c.periph = 1'b1;
      cfg(8'h60);
      idle(6);
      chk({4'h0, pad_oe[6:5], pad_out[5], periph_in[5]}, 8'h07);
      results();
   end
endmodule : tb_general_purpose_io_port
